// file: design/snp_pkg.sv
// constants and types for the station number positioning block
// Overview of operation
// - station positioning runs only while the method select register holds zero
// - geometry bit: 0 linear, 1 rotating with positions 0 to span minus one
// - stations per rotation accepted from 1 to 4096, default 1, evenly spaced
// - with BCD coding the stations count is limited to 1 to 1000
// - machine zero is station 0, set by the zero point event
// - station numbers rise in the forward direction up to count minus one
// - numbering bit: 0 gives stations 0..N-1, 1 gives stations 1..N
// - code bit: command inputs read as binary when 0, BCD when 1
// - binary weights 1..2048; BCD weights 1,2,4,8,10..80,100..800
// - command value is the sum of weights of inputs driven low
// - mode bit: absolute station command when 0, incremental when 1
// - absolute mode takes the decoded value as the target station
// - incremental target is the resting station plus or minus the value
// - BCD digit groups above 9, 90 or 900 raise a position error
// - absolute direction: open/open shortest, a forward, b reverse, both error
// - a start pulse launches positioning on inputs valid at that moment
package snp_pkg;
    localparam int CMD_W  = 12;
    localparam int ST_W   = 13;
    localparam int SPAN_W = 24;

    localparam logic [7:0] OFS_METHOD  = 8'h00;
    localparam logic [7:0] OFS_CONFIG  = 8'h04;
    localparam logic [7:0] OFS_FEATURE = 8'h08;
    localparam logic [7:0] OFS_NSTAT   = 8'h0c;
    localparam logic [7:0] OFS_SPAN    = 8'h10;
    localparam logic [7:0] OFS_CUR     = 8'h14;
    localparam logic [7:0] OFS_TARGET  = 8'h18;
    localparam logic [7:0] OFS_TPOS    = 8'h1c;
    localparam logic [7:0] OFS_STATUS  = 8'h20;
    localparam logic [7:0] OFS_MASK    = 8'h24;

    localparam int BIT_ROTATE  = 2;
    localparam int BIT_INCR    = 3;
    localparam int BIT_BCD     = 4;
    localparam int BIT_ONEBASE = 3;

    localparam int EV_ISSUED = 0;
    localparam int EV_ERROR  = 1;
    localparam int EV_ARRIVE = 2;
    localparam int EV_W      = 3;

    localparam logic [ST_W-1:0]   NSTAT_RST  = 13'h0001;
    localparam logic [ST_W-1:0]   NSTAT_MAX  = 13'h1000;
    localparam logic [ST_W-1:0]   NSTAT_BCD  = 13'h03e8;
    localparam logic [SPAN_W-1:0] SPAN_RST   = 24'h010000;
    localparam logic [3:0]        BCD_DIGMAX = 4'h9;
    localparam logic [ST_W-1:0]   BCD_TEN    = 13'h000a;
    localparam logic [ST_W-1:0]   BCD_HUND   = 13'h0064;

    typedef enum logic [2:0] {
        S_IDLE, S_CHECK, S_WRAP, S_SCALE
    } snp_state_t;
endpackage : snp_pkg

// file: design/snp_muldiv.sv
// sequential (a*b)/d unit: quotient and remainder after one bit per clock
module snp_muldiv #(
    parameter int AW = 13,
    parameter int BW = 24
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // request
    input  wire logic          start,
    input  wire logic [AW-1:0] opA,
    input  wire logic [BW-1:0] opB,
    input  wire logic [AW-1:0] divisor,
    // answer
    output logic      [BW-1:0] quot,
    output logic      [AW-1:0] rem,
    output logic               done
);
    localparam int PW = AW + BW;
    localparam int CW = $clog2(PW + 1);

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] cnt;
        logic [PW-1:0] num;
        logic [PW-1:0] q;
        logic [AW:0]   acc;
        logic [AW-1:0] d;
        logic [BW-1:0] quot;
        logic [AW-1:0] rem;
        logic          done;
    } snp_div_t;

    snp_div_t r, next_r;

    always_comb begin
        logic [AW:0] t;
        t = '0;
        next_r = r;
        next_r.done = 1'b0;
        if (start) begin
            next_r.busy = 1'b1;
            next_r.cnt  = CW'(PW);
            next_r.num  = PW'(opA) * PW'(opB);
            next_r.acc  = '0;
            next_r.q    = '0;
            next_r.d    = divisor;
        end else if (r.busy) begin
            // restoring division, msb of the product first
            t = {r.acc[AW-1:0], r.num[PW-1]};
            next_r.num = {r.num[PW-2:0], 1'b0};
            if (t >= {1'b0, r.d}) begin
                next_r.acc = t - {1'b0, r.d};
                next_r.q   = {r.q[PW-2:0], 1'b1};
            end else begin
                next_r.acc = t;
                next_r.q   = {r.q[PW-2:0], 1'b0};
            end
            next_r.cnt = r.cnt - CW'(1);
            if (r.cnt == CW'(1)) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.quot = next_r.q[BW-1:0];
                next_r.rem  = next_r.acc[AW-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign quot = r.quot;
    assign rem  = r.rem;
    assign done = r.done;
endmodule : snp_muldiv

// file: design/snp_station_pos.sv
// station number positioning: command decode, target, direction, apb registers
module snp_station_pos
    import snp_pkg::*;
#(
    parameter logic [SPAN_W-1:0] SPAN_DEFAULT = SPAN_RST
) (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rstn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // contact inputs, low means closed; the start pulse is high active
    input  wire logic [snp_pkg::CMD_W-1:0] stationCmdInN,
    input  wire logic                      directionSelectAN,
    input  wire logic                      directionSelectBN,
    input  wire logic                      operationStartIn,
    // servo loop events
    input  wire logic                      posDoneIn,
    input  wire logic                      zeroPointIn,
    // move request to the servo loop
    output logic      [snp_pkg::ST_W-1:0]  targetStation,
    output logic      [snp_pkg::SPAN_W-1:0] targetPos,
    output logic                           moveStart,
    output logic                           moveDirFwd,
    output logic                           posError,
    output logic                           irq
);
    import snp_pkg::*;

    typedef struct packed {
        snp_state_t        st;
        logic [2:0]        methodSel;
        logic              rotating;
        logic              incMode;
        logic              bcdCode;
        logic              oneBased;
        logic [ST_W-1:0]   nStations;
        logic [SPAN_W-1:0] span;
        logic [ST_W-1:0]   curSt;
        logic [ST_W-1:0]   tgtSt;
        logic [ST_W-1:0]   tgtOut;
        logic [CMD_W-1:0]  cmdRaw;
        logic              dirA;
        logic              dirB;
        logic [SPAN_W-1:0] tgtPos;
        logic              moveStart;
        logic              moveDirFwd;
        logic              posError;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   mask;
        logic              irq;
        logic              divStart;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } snp_regs_t;

    snp_regs_t r, next_r;

    logic [SPAN_W-1:0] divQuot;
    logic [ST_W-1:0]   divRem;
    logic              divDone;
    logic [ST_W-1:0]   divA;
    logic [SPAN_W-1:0] divB;

    // one unit serves both the wrap and the scaling, so they never overlap
    assign divA = (r.st == S_WRAP) ? ST_W'(cmdValue(r.cmdRaw, r.bcdCode)) : r.tgtSt;
    assign divB = (r.st == S_WRAP) ? SPAN_W'(1) : r.span;

    snp_muldiv #(
        .AW(ST_W),
        .BW(SPAN_W)
    ) u_muldiv (
        .clk_sys(clk_sys),
        .rstn   (rstn),
        .start  (r.divStart),
        .opA    (divA),
        .opB    (divB),
        .divisor(r.nStations),
        .quot   (divQuot),
        .rem    (divRem),
        .done   (divDone)
    );

    function automatic logic [ST_W-1:0] cmdValue(input logic [CMD_W-1:0] c,
                                                 input logic bcd);
        if (bcd) begin
            cmdValue = ST_W'(c[3:0]) + ST_W'(c[7:4]) * BCD_TEN
                     + ST_W'(c[11:8]) * BCD_HUND;
        end else begin
            cmdValue = ST_W'(c);
        end
    endfunction : cmdValue

    // closed contacts count, open ones contribute nothing
    logic [CMD_W-1:0] cmdClosed;
    assign cmdClosed = ~stationCmdInN;

    logic [ST_W-1:0] cmdVal;
    logic [ST_W-1:0] base;
    logic            bcdBad;
    logic            nBad;
    assign cmdVal = cmdValue(r.cmdRaw, r.bcdCode);
    assign base   = r.oneBased ? ST_W'(1) : ST_W'(0);
    assign bcdBad = r.bcdCode && (r.cmdRaw[3:0] > BCD_DIGMAX
                 || r.cmdRaw[7:4] > BCD_DIGMAX || r.cmdRaw[11:8] > BCD_DIGMAX);
    assign nBad   = r.nStations == '0 || r.nStations > NSTAT_MAX
                 || (r.bcdCode && r.nStations > NSTAT_BCD);

    logic apbAcc;
    logic apbWr;
    logic nWrOk;
    assign apbAcc = psel && penable && !r.pready;
    assign apbWr  = psel && penable && r.pready && pwrite;
    assign nWrOk  = pwdata[ST_W-1:0] != '0 && ST_W'(pwdata[ST_W-1:0]) <= NSTAT_MAX
                 && pwdata[31:ST_W] == '0 && !(r.bcdCode && pwdata[ST_W-1:0] > NSTAT_BCD);

    always_comb begin
        logic [ST_W-1:0]  idx;
        logic [ST_W:0]    sum;
        logic [ST_W-1:0]  diff;
        logic [EV_W-1:0]  ev;
        logic             err;
        logic             fwd;
        idx  = '0;
        sum  = '0;
        diff = '0;
        ev   = '0;
        err  = 1'b0;
        fwd  = r.dirA;
        next_r = r;
        next_r.moveStart = 1'b0;
        next_r.divStart  = 1'b0;

        case (r.st)
            S_IDLE: begin
                // inputs captured at the start, later changes are ignored
                if (operationStartIn && r.methodSel == 3'h0) begin
                    next_r.st     = S_CHECK;
                    next_r.cmdRaw = cmdClosed;
                    next_r.dirA   = !directionSelectAN;
                    next_r.dirB   = !directionSelectBN;
                end
            end
            S_CHECK: begin
                err = nBad || bcdBad;
                if (!r.incMode) begin
                    err = err || (r.dirA && r.dirB);
                    err = err || cmdVal < base || cmdVal - base >= r.nStations;
                    idx = cmdVal - base;
                end else begin
                    err = err || (r.dirA == r.dirB);
                end
                if (err) begin
                    next_r.posError = 1'b1;
                    ev[EV_ERROR]    = 1'b1;
                    next_r.st       = S_IDLE;
                end else if (!r.incMode) begin
                    next_r.tgtSt = idx;
                    diff = (idx >= r.curSt) ? idx - r.curSt
                                            : idx + r.nStations - r.curSt;
                    // shortest way, ties go forward
                    if (!r.dirA && !r.dirB) begin
                        fwd = {diff, 1'b0} <= {1'b0, r.nStations};
                    end
                    next_r.moveDirFwd = fwd;
                    next_r.st         = S_SCALE;
                    next_r.divStart   = 1'b1;
                end else if (r.rotating) begin
                    next_r.st       = S_WRAP;
                    next_r.divStart = 1'b1;
                end else begin
                    // linear incremental: no wrap, leaving the range is an error
                    sum = r.dirA ? {1'b0, r.curSt} + {1'b0, cmdVal}
                                 : {1'b0, r.curSt} - {1'b0, cmdVal};
                    if (sum[ST_W] || sum[ST_W-1:0] >= r.nStations) begin
                        next_r.posError = 1'b1;
                        ev[EV_ERROR]    = 1'b1;
                        next_r.st       = S_IDLE;
                    end else begin
                        next_r.tgtSt      = sum[ST_W-1:0];
                        next_r.moveDirFwd = r.dirA;
                        next_r.st         = S_SCALE;
                        next_r.divStart   = 1'b1;
                    end
                end
            end
            S_WRAP: begin
                if (divDone) begin
                    if (r.dirA) begin
                        sum = {1'b0, r.curSt} + {1'b0, divRem};
                        if (sum >= {1'b0, r.nStations}) begin
                            sum = sum - {1'b0, r.nStations};
                        end
                    end else begin
                        sum = (r.curSt >= divRem)
                            ? {1'b0, r.curSt - divRem}
                            : {1'b0, r.curSt + r.nStations - divRem};
                    end
                    next_r.tgtSt      = sum[ST_W-1:0];
                    next_r.moveDirFwd = r.dirA;
                    next_r.st         = S_SCALE;
                    next_r.divStart   = 1'b1;
                end
            end
            S_SCALE: begin
                // even spacing: station times span over stations count
                if (divDone) begin
                    next_r.tgtPos    = divQuot;
                    next_r.moveStart = 1'b1;
                    next_r.posError  = 1'b0;
                    ev[EV_ISSUED]    = 1'b1;
                    next_r.st        = S_IDLE;
                end
            end
            default: begin
                next_r.st = S_IDLE;
            end
        endcase

        // resting station follows the servo loop; zero point wins
        if (zeroPointIn) begin
            next_r.curSt = '0;
        end else if (posDoneIn) begin
            next_r.curSt = r.tgtSt;
            ev[EV_ARRIVE] = 1'b1;
        end

        // apb: pready one cycle into the access phase, read data at that edge, writes take effect at the next one
        next_r.pready  = apbAcc;
        next_r.pslverr = 1'b0;
        next_r.prdata  = '0;
        if (apbAcc) begin
            case (paddr)
                OFS_METHOD:  next_r.prdata = 32'(r.methodSel);
                OFS_CONFIG:  next_r.prdata = 32'({r.bcdCode, r.incMode, r.rotating}) << BIT_ROTATE;
                OFS_FEATURE: next_r.prdata = 32'(r.oneBased) << BIT_ONEBASE;
                OFS_NSTAT:   next_r.prdata = 32'(r.nStations);
                OFS_SPAN:    next_r.prdata = 32'(r.span);
                OFS_CUR:     next_r.prdata = 32'(r.curSt + base);
                OFS_TARGET:  next_r.prdata = 32'(r.tgtSt + base);
                OFS_TPOS:    next_r.prdata = 32'(r.tgtPos);
                OFS_STATUS:  next_r.prdata = 32'(r.status);
                OFS_MASK:    next_r.prdata = 32'(r.mask);
                default:     next_r.pslverr = 1'b1;
            endcase
        end
        if (apbWr) begin
            case (paddr)
                OFS_METHOD:  next_r.methodSel = pwdata[2:0];
                OFS_CONFIG: begin
                    next_r.rotating = pwdata[BIT_ROTATE];
                    next_r.incMode  = pwdata[BIT_INCR];
                    next_r.bcdCode  = pwdata[BIT_BCD];
                end
                OFS_FEATURE: next_r.oneBased = pwdata[BIT_ONEBASE];
                OFS_NSTAT: begin
                    // out of range values are dropped, the old count stays
                    if (nWrOk) begin
                        next_r.nStations = pwdata[ST_W-1:0];
                    end
                end
                OFS_SPAN: begin
                    if (pwdata[SPAN_W-1:0] != '0) begin
                        next_r.span = pwdata[SPAN_W-1:0];
                    end
                end
                OFS_STATUS:  next_r.status = r.status & ~pwdata[EV_W-1:0];
                OFS_MASK:    next_r.mask = pwdata[EV_W-1:0];
                default:     next_r.status = r.status;
            endcase
        end
        // a new event beats a clear in the same cycle
        next_r.status = next_r.status | ev;
        next_r.irq    = |(next_r.status & next_r.mask);
        // user numbering kept in a flop so the output pin has no adder behind it
        next_r.tgtOut = next_r.tgtSt + (next_r.oneBased ? ST_W'(1) : ST_W'(0));
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r           <= '0;
            r.st        <= S_IDLE;
            r.nStations <= NSTAT_RST;
            r.span      <= SPAN_DEFAULT;
        end else begin
            r <= next_r;
        end
    end

    assign prdata        = r.prdata;
    assign pready        = r.pready;
    assign pslverr       = r.pslverr;
    assign targetStation = r.tgtOut;
    assign targetPos     = r.tgtPos;
    assign moveStart     = r.moveStart;
    assign moveDirFwd    = r.moveDirFwd;
    assign posError      = r.posError;
    assign irq           = r.irq;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_method_gate: assert property (
        r.st == S_IDLE && r.methodSel != 3'h0 |=> r.st == S_IDLE)
        else $error("start taken with another method selected");
    a_start_taken: assert property (
        r.st == S_IDLE && operationStartIn && r.methodSel == 3'h0
        |=> r.st == S_CHECK && r.cmdRaw == $past(cmdClosed))
        else $error("start not taken with inputs");
    a_nstat_range: assert property (
        r.nStations != '0 && r.nStations <= NSTAT_MAX)
        else $error("stations count out of range");
    a_bcd_digit: assert property (
        r.st == S_CHECK && bcdBad |=> r.posError && r.st == S_IDLE)
        else $error("bad bcd digit not flagged");
    a_abs_both: assert property (
        r.st == S_CHECK && !r.incMode && r.dirA && r.dirB |=> r.posError)
        else $error("both contacts closed not flagged");
    a_inc_open: assert property (
        r.st == S_CHECK && r.incMode && !r.dirA && !r.dirB |=> r.posError)
        else $error("incremental with open contacts not flagged");
    a_abs_target: assert property (
        r.moveStart && !r.incMode |-> r.tgtSt + base == cmdVal)
        else $error("absolute target differs from command");
    a_tgt_wrap: assert property (
        r.moveStart |-> r.tgtSt < r.nStations && r.tgtPos < r.span)
        else $error("target outside one rotation");
    a_zero_point: assert property (
        zeroPointIn |=> r.curSt == '0)
        else $error("zero point did not reset station");
    a_dir_pick: assert property (
        r.st == S_CHECK && !r.incMode && r.dirA && !r.dirB && !bcdBad && !nBad
        ##1 r.st == S_SCALE |-> r.moveDirFwd)
        else $error("forward contact ignored");

    c_abs_move: cover property (r.moveStart && !r.incMode && !r.dirA && !r.dirB);
    c_inc_wrap: cover property (r.st == S_WRAP ##[1:60] r.moveStart);
    c_error:    cover property (r.st == S_CHECK ##1 r.posError);
endmodule : snp_station_pos

// file: tb/snp_contact_host.sv
// host controller model: contact command, start pulse and servo arrival answer
module snp_contact_host (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // request from the bench
    input  wire logic        reqGo,
    input  wire logic [11:0] reqClosed,
    input  wire logic [1:0]  reqDir,
    input  wire logic [3:0]  reqLag,
    input  wire logic        moveStart,
    // contacts and servo answer
    output logic      [11:0] stationCmdInN,
    output logic             directionSelectAN,
    output logic             directionSelectBN,
    output logic             operationStartIn,
    output logic             posDoneIn
);
    logic [4:0] lagCnt;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stationCmdInN     <= 12'hfff;
            directionSelectAN <= 1'b1;
            directionSelectBN <= 1'b1;
            operationStartIn  <= 1'b0;
            posDoneIn         <= 1'b0;
            lagCnt            <= 5'h00;
        end else begin
            operationStartIn <= reqGo;
            posDoneIn        <= (lagCnt == 5'h01);
            if (reqGo) begin
                stationCmdInN     <= ~reqClosed;
                directionSelectAN <= ~reqDir[0];
                directionSelectBN <= ~reqDir[1];
            end else if (operationStartIn) begin
                // contacts only hold at the start edge; flip them so a late sample shows
                stationCmdInN     <= ~stationCmdInN;
                directionSelectAN <= ~directionSelectAN;
                directionSelectBN <= ~directionSelectBN;
            end
            if (moveStart)
                lagCnt <= {1'b0, reqLag} + 5'h02;
            else if (lagCnt != 5'h00)
                lagCnt <= lagCnt - 5'h01;
        end
    end
endmodule : snp_contact_host

// file: tb/station_number_positioning_test.sv
// self-checking bench for the station number positioning block
module station_number_positioning_test;
    timeunit 1ns;
    timeprecision 1ps;
    import snp_pkg::*;
    logic              clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0, prdata, rd;
    logic              pready, pslverr, er, zeroPointIn = 1'b0, reqGo = 1'b0;
    logic [11:0]       stationCmdInN, reqClosed = 12'h000;
    logic [1:0]        reqDir = 2'h0;
    logic [3:0]        reqLag = 4'h0;
    logic              directionSelectAN, directionSelectBN, operationStartIn, posDoneIn;
    logic [ST_W-1:0]   targetStation;
    logic [SPAN_W-1:0] targetPos, span;
    logic              moveStart, moveDirFwd, posError, irq;
    int                failCount = 0, totalChecks = 0, n, cur, one, rot, incr, bcd, r, j, v;

    always #4 clk_sys = ~clk_sys;

    snp_station_pos i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stationCmdInN(stationCmdInN), .directionSelectAN(directionSelectAN),
        .directionSelectBN(directionSelectBN), .operationStartIn(operationStartIn),
        .posDoneIn(posDoneIn), .zeroPointIn(zeroPointIn), .targetStation(targetStation),
        .targetPos(targetPos), .moveStart(moveStart), .moveDirFwd(moveDirFwd),
        .posError(posError), .irq(irq));
    snp_contact_host i_host (.clk_sys(clk_sys), .rstn(rstn), .reqGo(reqGo),
        .reqClosed(reqClosed), .reqDir(reqDir), .reqLag(reqLag), .moveStart(moveStart),
        .stationCmdInN(stationCmdInN), .directionSelectAN(directionSelectAN),
        .directionSelectBN(directionSelectBN), .operationStartIn(operationStartIn),
        .posDoneIn(posDoneIn));

    task automatic testDone();
        $display("Checks %0d, mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : testDone

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        check(pready, 1'b1);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    function automatic void expectMove(input logic [11:0] cl, input logic [1:0] dr,
            output bit e, output int t, output bit f);
        int val, s, d;
        val = bcd ? cl[3:0] + 10 * cl[7:4] + 100 * cl[11:8] : int'(cl);
        e = bcd && (n > 1000 || cl[3:0] > 9 || cl[7:4] > 9 || cl[11:8] > 9);
        f = (dr == 2'd1);
        if (!incr) begin
            t = val - one;
            e |= (dr == 2'd3) || t < 0 || t >= n;
            d = (t - cur + n) % n;
            if (dr == 2'd0) f = (2 * d <= n);
        end else begin
            s = dr[0] ? cur + val : cur - val;
            e |= (dr == 2'd0) || (dr == 2'd3) || (!rot && (s < 0 || s >= n));
            t = ((s % n) + n) % n;
        end
    endfunction : expectMove

    task automatic move(input logic [11:0] cl, input logic [1:0] dr, input bit off);
        bit e, f, seen;
        int t, k;
        logic [2:0] m, sx;
        expectMove(cl, dr, e, t, f);
        e |= off;
        reqClosed <= cl; reqDir <= dr; reqLag <= 4'($urandom); reqGo <= 1'b1;
        @(posedge clk_sys);
        reqGo <= 1'b0;
        seen = 0;
        for (k = 0; k < 130 && !seen; k++) begin
            @(posedge clk_sys);
            if (moveStart === 1'b1) begin
                seen = 1;
                check(targetStation, t + one);
                check(targetPos, (64'(t) * span) / n);
                if (dr != 2'd0 || (rot && t != cur)) check(moveDirFwd, f);
            end
        end
        check(seen, !e);
        if (!off) check(posError, e);
        if (seen) cur = t;
        repeat (24) @(posedge clk_sys);
        rdchk(OFS_CUR, cur + one);
        sx = off ? 3'b000 : (e ? 3'b010 : 3'b101);
        rdchk(OFS_STATUS, 32'(sx));
        m = 3'($urandom);
        apb(1'b1, OFS_MASK, 32'(m));
        check(irq, |(sx & m));
        apb(1'b1, OFS_STATUS, 32'h7);
        check(irq, 1'b0);
    endtask : move

    initial begin
        void'($urandom(74730));
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rdchk(OFS_NSTAT, 32'h1);
        rdchk(OFS_SPAN, 32'(SPAN_RST));
        rdchk(OFS_CONFIG, 32'h0);
        rdchk(OFS_FEATURE, 32'h0);
        apb(1'b1, OFS_NSTAT, 32'h0);
        apb(1'b1, OFS_NSTAT, 32'd4097);
        rdchk(OFS_NSTAT, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        check({er, rd}, {1'b1, 32'h0});
        for (r = 0; r < 40; r++) begin
            bcd = (r == 1) ? 1 : $urandom % 2;
            rot = $urandom % 2;
            incr = $urandom % 2;
            one = $urandom % 2;
            n = (r < 2) ? 4096 - 3096 * r : bcd ? 1 + $urandom % 1000 : 1 + $urandom % 4096;
            span = 24'($urandom) | 24'h1;
            apb(1'b1, OFS_CONFIG, 32'h0);
            apb(1'b1, OFS_NSTAT, 32'(n));
            apb(1'b1, OFS_SPAN, 32'(span));
            apb(1'b1, OFS_FEATURE, 32'(one << 3));
            apb(1'b1, OFS_CONFIG, 32'(bcd << 4 | incr << 3 | rot << 2));
            apb(1'b1, OFS_NSTAT, bcd ? 32'd1001 : 32'd4097);
            rdchk(OFS_NSTAT, 32'(n));
            zeroPointIn <= 1'b1;
            @(posedge clk_sys);
            zeroPointIn <= 1'b0;
            @(posedge clk_sys);
            cur = 0;
            rdchk(OFS_CUR, 32'(one));
            apb(1'b1, OFS_METHOD, 32'(r % 8 == 3));
            for (j = 0; j < 5; j++) begin
                v = ($urandom % 4 != 0) ? int'($urandom % n) + one : int'($urandom);
                if (bcd && v < 1000) v = (v / 100 % 10) << 8 | (v / 10 % 10) << 4 | v % 10;
                move(12'(v), 2'($urandom), r % 8 == 3);
            end
            apb(1'b1, OFS_METHOD, 32'h0);
        end
        testDone();
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        failCount++;
        testDone();
    end
endmodule : station_number_positioning_test
